//--- pot_pkg.sv
// Shared constants and types for the partition output state tracker.
package pot_pkg;
    // Register byte offsets.
    localparam logic [7:0] OFF_CMD = 8'h00;
    localparam logic [7:0] OFF_STATUS = 8'h04;
    localparam logic [7:0] OFF_OUTSEL = 8'h08;
    localparam logic [7:0] OFF_STATE = 8'h0c;
    // Command register fields.
    localparam int CMD_PART_LSB = 16;
    localparam int CMD_BLK_LSB = 20;
    // Command codes.
    localparam logic [7:0] CMD_READ_ARRAY = 8'hff;
    localparam logic [7:0] CMD_WORD_PGM = 8'h41;
    localparam logic [7:0] CMD_BP_SETUP = 8'he9;
    localparam logic [7:0] CMD_ERASE = 8'h20;
    localparam logic [7:0] CMD_BULK_FACTORY_PROGRAM = 8'h80;
    localparam logic [7:0] CMD_CONFIRM = 8'hd0;
    localparam logic [7:0] CMD_SUSPEND = 8'hb0;
    localparam logic [7:0] CMD_READ_STATUS = 8'h70;
    localparam logic [7:0] CMD_CLEAR_STATUS = 8'h50;
    localparam logic [7:0] CMD_READ_ID = 8'h90;
    localparam logic [7:0] CMD_READ_QUERY = 8'h98;
    localparam logic [7:0] CMD_LOCK_SETUP = 8'h60;
    localparam logic [7:0] CMD_BLANK_CHECK = 8'hbc;
    localparam logic [7:0] CMD_OTP = 8'hc0;
    localparam logic [7:0] CMD_LOCK = 8'h01;
    localparam logic [7:0] CMD_LOCK_DOWN = 8'h2f;
    localparam logic [7:0] CMD_CFG_RCR = 8'h03;
    localparam logic [7:0] CMD_CFG_ECR = 8'h04;
    // Status register bit positions and masks.
    localparam int SR_BUF_BUSY = 0;
    localparam int SR_LOCK_ERR = 1;
    localparam int SR_PGM_SUSP = 2;
    localparam int SR_PGM_ERR = 4;
    localparam int SR_ERS_ERR = 5;
    localparam int SR_ERS_SUSP = 6;
    localparam int SR_READY = 7;
    localparam logic [7:0] SR_ERR_MASK = 8'h3a;
    localparam logic [7:0] SR_SEQ_ERR = 8'h30;
    localparam logic [7:0] SR_ERR_RESET = 8'h00;
    // Output selection of one partition.
    typedef enum logic [1:0] {SEL_ARRAY, SEL_STATUS, SEL_IDQ} pot_sel_t;
    // Chip state.
    typedef enum logic [3:0] {
        ST_READY, ST_PGM_SETUP, ST_ERS_SETUP, ST_OTP_SETUP, ST_BC_SETUP,
        ST_BULK_FACTORY_PROGRAM_SETUP, ST_BULK_FACTORY_PROGRAM_BUSY, ST_LOCK_SETUP, ST_BP_SETUP,
        ST_BP_LOAD1, ST_BP_LOAD2, ST_BUSY, ST_PGM_SUSP, ST_ERS_SUSP
    } pot_state_t;
    // Operation handed to the write_state_machine.
    typedef enum logic [3:0] {
        OP_NONE, OP_PGM, OP_ERASE, OP_BP, OP_BULK_FACTORY_PROGRAM, OP_OTP, OP_BCHECK,
        OP_LOCK, OP_UNLOCK, OP_LOCK_DOWN, OP_CFG, OP_SUSPEND, OP_RESUME
    } pot_op_t;
endpackage : pot_pkg

//--- pot_tracker.sv
// Partition output state tracker: command decode, selections, status.
//
// Behaviour
// - each partition holds array, status or ID/query output selection.
// - a selection persists until a command is written at that partition.
// - codes outside the command set are illegal and flag an error, except while an operation is busy.
// - all partitions select array data after reset.
// - returning to a partition shows its stored selection again.
// - identification and query commands both select ID/query output.
// - clear-status clears error bits only when ready, not busy/suspended.
// - bulk_factory_program data taken only while status bit zero is zero.
// - next chip state ignores the stored partition selections.
// - lock, unlock, lock-down and config confirms return to the state before lock setup; blank check ends ready after busy.
// - buffer_program load at a different block aborts with sequence error.
// - in suspend a two-cycle erase, bulk, blank check or OTP command, or a program one in program suspend, is consumed whole, never resumes.
// - buffer_program setup leaves the partition selection unchanged.
// - buffer_program confirm selects status output for the partition.
//
// The address map and the APB slave port were decided locally.
`timescale 1ns/1ps
module pot_tracker
    import pot_pkg::*;
#(
    parameter int NPART = 8,
    parameter int BLK_W = 8,
    parameter int CNT_W = 5
)(
    // Clock and reset.
    input wire logic pclk,
    input wire logic presetn,
    // APB slave.
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // Write state machine side.
    input wire logic op_done,
    input wire logic buf_busy,
    input wire logic err_pgm,
    input wire logic err_ers,
    input wire logic err_lock,
    output logic op_start,
    output pot_op_t op_kind,
    output logic [BLK_W-1:0] op_block,
    output logic [15:0] op_data,
    output logic data_wr,
    // Read path selection.
    input wire logic [$clog2(NPART)-1:0] rd_part,
    output pot_sel_t rd_sel
);
    localparam int PART_W = $clog2(NPART);

    pot_state_t state_reg, state_next, ret_reg, ret_next;
    pot_state_t lock_ret_reg, lock_ret_next;
    pot_op_t kind_reg, go_kind;
    pot_sel_t outsel_reg [NPART];
    pot_sel_t sel_val;
    logic sel_wr, pend_reg, pend_next, err_clr, go, data_go, blk_load;
    logic [7:0] err_reg, err_set, status_reg;
    logic [BLK_W-1:0] first_cycle_block_addr_reg;
    logic [CNT_W-1:0] cnt_reg, cnt_next;
    logic [31:0] rd_mux;
    logic cmd_wr, blk_diff, wsm_busy;
    logic [7:0] code;
    logic [PART_W-1:0] cmd_part;
    logic [BLK_W-1:0] cmd_blk;

    // A command cycle lands on the access edge of a write to the command word.
    assign cmd_wr = psel && penable && pwrite && (paddr == OFF_CMD);
    assign code = pwdata[7:0];
    assign cmd_part = pwdata[CMD_PART_LSB +: PART_W];
    assign cmd_blk = pwdata[CMD_BLK_LSB +: BLK_W];
    assign blk_diff = cmd_blk != first_cycle_block_addr_reg;
    assign wsm_busy = (state_reg == ST_BUSY) || (state_reg == ST_BULK_FACTORY_PROGRAM_BUSY);

    // Command decode. Partition selections are never read here.
    always_comb
    begin
        state_next = state_reg;
        ret_next = ret_reg;
        lock_ret_next = lock_ret_reg;
        pend_next = pend_reg;
        cnt_next = cnt_reg;
        sel_wr = 1'b0;
        sel_val = SEL_STATUS;
        err_set = 8'h00;
        err_clr = 1'b0;
        go = 1'b0;
        go_kind = OP_NONE;
        data_go = 1'b0;
        blk_load = 1'b0;
        if (cmd_wr)
        begin
            case (state_reg)
                ST_READY, ST_PGM_SUSP, ST_ERS_SUSP:
                begin
                    if (pend_reg)
                    begin
                        // Second half of a pair given in suspend.
                        pend_next = 1'b0;
                        err_set = SR_SEQ_ERR;
                    end
                    else
                    begin
                        case (code)
                            CMD_READ_ARRAY:
                            begin
                                sel_wr = 1'b1;
                                sel_val = SEL_ARRAY;
                            end
                            CMD_READ_STATUS:
                                sel_wr = 1'b1;
                            CMD_READ_ID, CMD_READ_QUERY:
                            begin
                                sel_wr = 1'b1;
                                sel_val = SEL_IDQ;
                            end
                            CMD_CLEAR_STATUS:
                                err_clr = (state_reg == ST_READY);
                            CMD_WORD_PGM, CMD_BP_SETUP:
                            begin
                                // Buffer setup keeps the selection; word program setup selects status.
                                sel_wr = (code == CMD_WORD_PGM);
                                if (state_reg == ST_PGM_SUSP)
                                    pend_next = 1'b1;
                                else
                                begin
                                    ret_next = state_reg;
                                    blk_load = 1'b1;
                                    state_next = (code == CMD_WORD_PGM) ?
                                        ST_PGM_SETUP : ST_BP_SETUP;
                                end
                            end
                            CMD_ERASE, CMD_BULK_FACTORY_PROGRAM, CMD_BLANK_CHECK, CMD_OTP:
                            begin
                                sel_wr = 1'b1;
                                if (state_reg != ST_READY)
                                    pend_next = 1'b1;
                                else
                                begin
                                    ret_next = ST_READY;
                                    blk_load = 1'b1;
                                    case (code)
                                        CMD_ERASE: state_next = ST_ERS_SETUP;
                                        CMD_BULK_FACTORY_PROGRAM: state_next = ST_BULK_FACTORY_PROGRAM_SETUP;
                                        CMD_OTP: state_next = ST_OTP_SETUP;
                                        default: state_next = ST_BC_SETUP;
                                    endcase
                                end
                            end
                            CMD_LOCK_SETUP:
                            begin
                                sel_wr = 1'b1;
                                lock_ret_next = state_reg;
                                state_next = ST_LOCK_SETUP;
                            end
                            CMD_CONFIRM:
                            begin
                                // Resume the suspended operation.
                                if (state_reg != ST_READY)
                                begin
                                    go = 1'b1;
                                    go_kind = OP_RESUME;
                                    state_next = ST_BUSY;
                                end
                            end
                            CMD_SUSPEND, CMD_LOCK, CMD_LOCK_DOWN,
                            CMD_CFG_RCR, CMD_CFG_ECR:
                                sel_wr = 1'b0;
                            default:
                                err_set = SR_SEQ_ERR;
                        endcase
                    end
                end
                ST_PGM_SETUP, ST_OTP_SETUP:
                begin
                    sel_wr = 1'b1;
                    go = 1'b1;
                    data_go = 1'b1;
                    go_kind = (state_reg == ST_OTP_SETUP) ? OP_OTP : OP_PGM;
                    state_next = ST_BUSY;
                end
                ST_ERS_SETUP, ST_BC_SETUP, ST_BULK_FACTORY_PROGRAM_SETUP:
                begin
                    sel_wr = 1'b1;
                    if (code == CMD_CONFIRM)
                    begin
                        go = 1'b1;
                        case (state_reg)
                            ST_ERS_SETUP: go_kind = OP_ERASE;
                            ST_BC_SETUP: go_kind = OP_BCHECK;
                            default: go_kind = OP_BULK_FACTORY_PROGRAM;
                        endcase
                        state_next = (state_reg == ST_BULK_FACTORY_PROGRAM_SETUP) ?
                            ST_BULK_FACTORY_PROGRAM_BUSY : ST_BUSY;
                    end
                    else
                    begin
                        err_set = SR_SEQ_ERR;
                        state_next = ret_reg;
                    end
                end
                ST_BULK_FACTORY_PROGRAM_BUSY:
                begin
                    sel_wr = 1'b1;
                    // Words arriving while the buffer is busy are lost.
                    data_go = !buf_busy;
                end
                ST_LOCK_SETUP:
                begin
                    sel_wr = 1'b1;
                    state_next = lock_ret_reg;
                    go = 1'b1;
                    case (code)
                        CMD_LOCK: go_kind = OP_LOCK;
                        CMD_CONFIRM: go_kind = OP_UNLOCK;
                        CMD_LOCK_DOWN: go_kind = OP_LOCK_DOWN;
                        CMD_CFG_RCR, CMD_CFG_ECR:
                        begin
                            go_kind = OP_CFG;
                            sel_val = SEL_ARRAY;
                        end
                        default:
                        begin
                            go = 1'b0;
                            err_set = SR_SEQ_ERR;
                        end
                    endcase
                end
                ST_BP_SETUP:
                begin
                    cnt_next = pwdata[CNT_W-1:0];
                    state_next = ST_BP_LOAD1;
                end
                ST_BP_LOAD1, ST_BP_LOAD2:
                begin
                    if (blk_diff)
                    begin
                        err_set = SR_SEQ_ERR;
                        state_next = ret_reg;
                    end
                    else if (state_reg == ST_BP_LOAD1)
                    begin
                        data_go = 1'b1;
                        cnt_next = cnt_reg - 1'b1;
                        if (cnt_reg == '0)
                            state_next = ST_BP_LOAD2;
                    end
                    else if (code == CMD_CONFIRM)
                    begin
                        sel_wr = 1'b1;
                        go = 1'b1;
                        go_kind = OP_BP;
                        state_next = ST_BUSY;
                    end
                    else
                    begin
                        err_set = SR_SEQ_ERR;
                        state_next = ret_reg;
                    end
                end
                ST_BUSY:
                begin
                    sel_wr = (code != CMD_SUSPEND) &&
                        (code != CMD_CLEAR_STATUS);
                    if (code == CMD_READ_ARRAY)
                        sel_val = SEL_ARRAY;
                    else if (code == CMD_READ_ID || code == CMD_READ_QUERY)
                        sel_val = SEL_IDQ;
                    if (code == CMD_SUSPEND && kind_reg != OP_OTP &&
                        kind_reg != OP_BCHECK)
                    begin
                        go = 1'b1;
                        go_kind = OP_SUSPEND;
                        state_next = (kind_reg == OP_ERASE) ?
                            ST_ERS_SUSP : ST_PGM_SUSP;
                    end
                end
                default:
                    state_next = ST_READY;
            endcase
        end
        // Completion wins over a command in the same cycle.
        if (op_done && wsm_busy)
        begin
            state_next = ret_reg;
            ret_next = ST_READY;
        end
    end

    // Chip state and return points.
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            state_reg <= ST_READY;
            ret_reg <= ST_READY;
            lock_ret_reg <= ST_READY;
            pend_reg <= 1'b0;
            cnt_reg <= '0;
        end
        else
        begin
            state_reg <= state_next;
            ret_reg <= ret_next;
            lock_ret_reg <= lock_ret_next;
            pend_reg <= pend_next;
            cnt_reg <= cnt_next;
        end
    end

    // Block latched on the first write cycle of an operation.
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            first_cycle_block_addr_reg <= '0;
        else if (blk_load)
            first_cycle_block_addr_reg <= cmd_blk;
    end

    // Per-partition selections; only the addressed one changes.
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            for (int i = 0; i < NPART; i++)
                outsel_reg[i] <= SEL_ARRAY;
        end
        else if (sel_wr)
            outsel_reg[cmd_part] <= sel_val;
    end

    // The read path sees the stored selection of its partition.
    assign rd_sel = outsel_reg[rd_part];

    // Error bits are sticky; a new error beats a clear in the same cycle.
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            err_reg <= SR_ERR_RESET;
        else
            err_reg <= (err_reg & ~(err_clr ? SR_ERR_MASK : 8'h00)) |
                err_set | {2'b00, err_ers, err_pgm, 2'b00, err_lock, 1'b0};
    end

    always_comb
    begin
        status_reg = err_reg & SR_ERR_MASK;
        status_reg[SR_READY] = !wsm_busy;
        status_reg[SR_ERS_SUSP] = (state_reg == ST_ERS_SUSP) ||
            (ret_reg == ST_ERS_SUSP);
        status_reg[SR_PGM_SUSP] = state_reg == ST_PGM_SUSP;
        status_reg[SR_BUF_BUSY] = buf_busy;
    end

    // Requests toward the write state machine, one-cycle pulses.
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            op_start <= 1'b0;
            op_kind <= OP_NONE;
            kind_reg <= OP_NONE;
            op_block <= '0;
            op_data <= 16'h0000;
            data_wr <= 1'b0;
        end
        else
        begin
            op_start <= go;
            data_wr <= data_go;
            if (go)
                op_kind <= go_kind;
            if (go && go_kind != OP_SUSPEND && go_kind != OP_RESUME)
                kind_reg <= go_kind;
            else if (go && go_kind == OP_RESUME &&
                state_reg == ST_ERS_SUSP)
                kind_reg <= OP_ERASE; // A nested program may have ended.
            if (go || data_go)
            begin
                op_block <= cmd_blk;
                op_data <= pwdata[15:0];
            end
        end
    end

    // APB read mux; data is captured in the setup cycle.
    always_comb
    begin
        rd_mux = 32'h00000000;
        case (paddr)
            OFF_STATUS: rd_mux[7:0] = status_reg;
            OFF_OUTSEL:
                for (int i = 0; i < NPART; i++)
                    rd_mux[2*i +: 2] = outsel_reg[i];
            OFF_STATE: rd_mux[3:0] = state_reg;
            default: rd_mux = 32'h00000000;
        endcase
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            prdata <= 32'h00000000;
        else if (psel && !penable)
            prdata <= rd_mux;
    end

    // Zero wait states; unmapped addresses and writes to read-only words err.
    assign pready = 1'b1;
    assign pslverr = psel && penable && (pwrite ? (paddr != OFF_CMD) :
        (paddr != OFF_STATUS && paddr != OFF_OUTSEL && paddr != OFF_STATE));

    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    chk_ready_array: assert property (
        cmd_wr && state_reg == ST_READY && code == CMD_READ_ARRAY
        |=> outsel_reg[$past(cmd_part)] == SEL_ARRAY)
        else $error("read array did not select array");
    chk_id_query: assert property (
        cmd_wr && state_reg == ST_READY &&
        (code == CMD_READ_ID || code == CMD_READ_QUERY)
        |=> outsel_reg[$past(cmd_part)] == SEL_IDQ)
        else $error("id or query did not select id output");
    chk_bp_setup_keep: assert property (
        cmd_wr && code == CMD_BP_SETUP && state_reg == ST_READY
        |=> outsel_reg[$past(cmd_part)] == $past(outsel_reg[cmd_part]))
        else $error("buffer setup changed selection");
    chk_bp_confirm: assert property (
        cmd_wr && state_reg == ST_BP_LOAD2 && !blk_diff &&
        code == CMD_CONFIRM |=> outsel_reg[$past(cmd_part)] == SEL_STATUS
        ##0 state_reg == ST_BUSY ##1 op_kind == OP_BP)
        else $error("buffer confirm mishandled");
    chk_illegal_err: assert property (
        cmd_wr && state_reg == ST_READY && !pend_reg && code == 8'h11
        |=> status_reg[SR_ERS_ERR] && status_reg[SR_PGM_ERR]
        ##1 status_reg[SR_PGM_ERR])
        else $error("illegal command not flagged");
    // No error bit may drop when clear is given outside ready.
    chk_clr_busy: assert property (
        cmd_wr && code == CMD_CLEAR_STATUS && state_reg != ST_READY
        |=> (err_reg & $past(err_reg) & SR_ERR_MASK) ==
        ($past(err_reg) & SR_ERR_MASK))
        else $error("clear status acted outside ready");
    chk_bulk_factory_program_gate: assert property (
        cmd_wr && state_reg == ST_BULK_FACTORY_PROGRAM_BUSY && buf_busy |=> !data_wr)
        else $error("bulk write taken while buffer busy");
    chk_bp_block: assert property (
        cmd_wr && state_reg == ST_BP_LOAD1 && blk_diff
        |=> state_reg != ST_BP_LOAD1 && state_reg != ST_BUSY &&
        status_reg[SR_PGM_ERR])
        else $error("block change did not abort buffer load");
    chk_susp_pair: assert property (cmd_wr && pend_reg &&
        state_reg == ST_PGM_SUSP |=> state_reg == ST_PGM_SUSP && !op_start)
        else $error("pair in suspend resumed program");
    chk_lock_ready: assert property (
        cmd_wr && state_reg == ST_LOCK_SETUP && lock_ret_reg == ST_READY &&
        code == CMD_LOCK |=> state_reg == ST_READY && op_start &&
        op_kind == OP_LOCK)
        else $error("lock confirm did not return ready");
    chk_setup_status: assert property (cmd_wr &&
        state_reg == ST_PGM_SETUP |=> outsel_reg[$past(cmd_part)] ==
        SEL_STATUS ##0 state_reg == ST_BUSY)
        else $error("program setup did not select status");

    cov_bp_flow: cover property (state_reg == ST_BP_LOAD2 ##1
        state_reg == ST_BUSY);
    cov_suspend: cover property (state_reg == ST_BUSY ##1
        state_reg == ST_ERS_SUSP);
    cov_bulk_factory_program_drop: cover property (cmd_wr && state_reg == ST_BULK_FACTORY_PROGRAM_BUSY &&
        buf_busy);
endmodule : pot_tracker

//--- pot_wsm_model.sv
// Behavioural write state machine that answers the tracker's requests.
`timescale 1ns/1ps
module pot_wsm_model #(
    parameter int DELAY = 12
)(
    // Clock and reset.
    input wire logic pclk,
    input wire logic presetn,
    // Requests from the tracker.
    input wire logic op_start,
    input wire logic data_wr,
    // Answers to the tracker.
    output logic op_done,
    output logic buf_busy,
    output logic err_pgm,
    output logic err_ers,
    output logic err_lock
);
    logic [7:0] cnt_reg;
    logic [1:0] busy_reg;
    // A started operation ends a fixed time later, as a slow array would.
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            cnt_reg <= 8'h00;
        else if (op_start)
            cnt_reg <= 8'(DELAY);
        else if (cnt_reg != 8'h00)
            cnt_reg <= cnt_reg - 8'h01;
    end
    // The buffer stays busy briefly after each accepted word.
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            busy_reg <= 2'h0;
        else
            busy_reg <= data_wr ? 2'h2 : busy_reg >> 1;
    end
    assign op_done = (cnt_reg == 8'h01);
    assign buf_busy = |busy_reg;
    // The array never reports a failure in these runs.
    assign err_pgm = 1'b0;
    assign err_ers = 1'b0;
    assign err_lock = 1'b0;
endmodule : pot_wsm_model

//--- partition_output_state_tracker_tb_top.sv
// Testbench for the partition output state tracker.
`timescale 1ns/1ps
module partition_output_state_tracker_tb_top;
    import pot_pkg::*;
    logic pclk = 1'b0, presetn, psel, penable, pwrite, pready, pslverr;
    logic op_done, buf_busy, err_pgm, err_ers, err_lock, op_start, data_wr;
    logic [7:0] paddr, op_block;
    logic [31:0] pwdata, prdata, rdat;
    logic [15:0] op_data;
    logic [2:0] rd_part;
    pot_op_t op_kind;
    pot_sel_t rd_sel;
    int num_errors = 0;
    int check_count = 0;
    int nwr = 0;
    int n0;
    always #25 pclk = ~pclk;
    // Count data words handed to the write state machine.
    always @(posedge pclk)
        if (data_wr === 1'b1)
            nwr <= nwr + 1;
    pot_tracker dut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr,
        .pwdata, .prdata, .pready, .pslverr, .op_done, .buf_busy, .err_pgm,
        .err_ers, .err_lock, .op_start, .op_kind, .op_block, .op_data,
        .data_wr, .rd_part, .rd_sel);
    pot_wsm_model wsm (.pclk, .presetn, .op_start, .data_wr, .op_done,
        .buf_busy, .err_pgm, .err_ers, .err_lock);
    // One APB transfer; an idle edge first keeps psel from toggling twice.
    task automatic apb(input logic w, input logic [7:0] a,
        input logic [31:0] d);
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1);
        rdat = prdata;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb
    task automatic wr(input logic [7:0] c, input logic [2:0] p,
        input logic [7:0] b);
        apb(1'b1, OFF_CMD, {4'h0, b, 1'b0, p, 8'h00, c});
    endtask : wr
    task automatic chk(input string nm, input logic [31:0] e,
        input logic [31:0] g);
        check_count++;
        if (g !== e)
        begin
            num_errors++;
            $display("Error %s expected %h seen %h", nm, e, g);
        end
    endtask : chk
    task automatic seen(input logic [2:0] p, input pot_sel_t e);
        rd_part <= p;
        @(posedge pclk);
        #1 chk("rd_sel", 32'(e), 32'(rd_sel));
    endtask : seen
    // Poll status until idle; no array data is trusted while busy.
    task automatic wait_ready;
        do
            apb(1'b0, OFF_STATUS, 32'h0);
        while (rdat[SR_READY] !== 1'b1);
    endtask : wait_ready
    task automatic finish_test;
        $display("Checks %0d, mismatches %0d", check_count, num_errors);
        if (num_errors == 0 && check_count > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask : finish_test
    // The whole sequence needs well under a thousand cycles.
    initial
    begin
        repeat (5000) @(posedge pclk);
        num_errors++;
        $display("Error watchdog expected finish seen hang");
        finish_test();
    end
    initial
    begin
        {presetn, psel, penable, pwrite, paddr, pwdata, rd_part} = '0;
        repeat (16) @(posedge pclk);
        presetn <= 1'b1;
        apb(1'b0, OFF_OUTSEL, 32'h0);
        chk("outsel", 32'h0, rdat);
        wr(CMD_READ_STATUS, 3'h1, 8'h00);
        wr(CMD_READ_ID, 3'h2, 8'h00);
        wr(CMD_READ_QUERY, 3'h3, 8'h00);
        apb(1'b0, OFF_OUTSEL, 32'h0);
        chk("outsel", 32'h0000_00a4, rdat);
        seen(3'h1, SEL_STATUS);
        wr(CMD_READ_ARRAY, 3'h1, 8'h00);
        seen(3'h2, SEL_IDQ);
        seen(3'h1, SEL_ARRAY);
        $display("Test selections finished");
        wr(8'h11, 3'h0, 8'h00);
        apb(1'b0, OFF_STATUS, 32'h0);
        chk("status", 32'(SR_SEQ_ERR), rdat & 32'(SR_ERR_MASK));
        wr(CMD_CLEAR_STATUS, 3'h0, 8'h00);
        apb(1'b0, OFF_STATUS, 32'h0);
        chk("status", 32'h0, rdat & 32'(SR_ERR_MASK));
        $display("Test illegal and clear finished");
        wr(CMD_BP_SETUP, 3'h4, 8'h05);
        seen(3'h4, SEL_ARRAY);
        wr(8'h00, 3'h4, 8'h05);
        wr(8'h5a, 3'h4, 8'h05);
        wr(CMD_CONFIRM, 3'h4, 8'h05);
        seen(3'h4, SEL_STATUS);
        wait_ready();
        wr(CMD_BP_SETUP, 3'h4, 8'h05);
        wr(8'h00, 3'h4, 8'h05);
        wr(8'h5a, 3'h4, 8'h06);
        apb(1'b0, OFF_STATUS, 32'h0);
        chk("status", 32'(SR_SEQ_ERR), rdat & 32'(SR_ERR_MASK));
        $display("Test buffered program finished");
        wr(CMD_CLEAR_STATUS, 3'h0, 8'h00);
        wr(CMD_WORD_PGM, 3'h5, 8'h02);
        seen(3'h5, SEL_STATUS);
        wr(8'h5a, 3'h5, 8'h02);
        wr(CMD_SUSPEND, 3'h5, 8'h02);
        wr(CMD_ERASE, 3'h5, 8'h02);
        wr(CMD_CONFIRM, 3'h5, 8'h02);
        apb(1'b0, OFF_STATE, 32'h0);
        chk("state", 32'(ST_PGM_SUSP), rdat);
        wr(CMD_CLEAR_STATUS, 3'h5, 8'h02);
        apb(1'b0, OFF_STATUS, 32'h0);
        chk("status", 32'(SR_SEQ_ERR), rdat & 32'(SR_ERR_MASK));
        wr(CMD_CONFIRM, 3'h5, 8'h02);
        wait_ready();
        wr(CMD_CLEAR_STATUS, 3'h5, 8'h02);
        $display("Test suspend finished");
        n0 = nwr;
        wr(CMD_BULK_FACTORY_PROGRAM, 3'h6, 8'h03);
        wr(CMD_CONFIRM, 3'h6, 8'h03);
        wr(8'h5a, 3'h6, 8'h03);
        wr(8'ha5, 3'h6, 8'h03);
        wait_ready();
        chk("data_wr", 32'(n0 + 1), 32'(nwr));
        wr(CMD_LOCK_SETUP, 3'h7, 8'h04);
        wr(CMD_LOCK, 3'h7, 8'h04);
        seen(3'h7, SEL_STATUS);
        wr(CMD_LOCK_SETUP, 3'h6, 8'h04);
        wr(CMD_CFG_RCR, 3'h6, 8'h04);
        seen(3'h6, SEL_ARRAY);
        apb(1'b0, OFF_STATE, 32'h0);
        chk("state", 32'(ST_READY), rdat);
        $display("Test bulk and lock finished");
        finish_test();
    end
endmodule : partition_output_state_tracker_tb_top
